//--- pkg/divider_pkg.sv
// constants, types and helpers shared by the cascaded divider channel
package divider_pkg;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_PRESCALE = 8'h04;
    localparam logic [7:0] OFF_STAGE1   = 8'h08;
    localparam logic [7:0] OFF_STAGE2   = 8'h0c;
    localparam logic [7:0] OFF_STATUS   = 8'h10;
    localparam logic [7:0] OFF_MEASURE  = 8'h14;
    localparam int CTRL_CORR_DIS = 0;
    localparam int CTRL_USE_EXT  = 1;
    localparam int CTRL_BYP1     = 2;
    localparam int CTRL_BYP2     = 3;
    localparam int ST_OUT        = 0;
    localparam int ST_FIX_OK     = 1;
    localparam int ST_BAD_BYP    = 2;
    localparam int ST_BAD_ORDER  = 3;
    localparam int ST_RATIO_LSB  = 8;
    localparam int MEAS_PER_LSB  = 16;
    localparam int CNT_W         = 4;
    localparam int RATIO_W       = 11;
    localparam int MEAS_W        = 16;
    localparam logic [2:0]  PRE_MIN       = 3'h2;
    localparam logic [2:0]  PRE_MAX       = 3'h6;
    localparam logic [2:0]  PRE_RESET     = 3'h2;
    localparam logic [7:0]  STAGE_RESET   = 8'h00;
    localparam logic [10:0] RATIO_ONE     = 11'h001;
    localparam logic [5:0]  RATIO_OFFSET  = 6'h02;
    localparam logic [1:0]  CFG_SETTLED   = 2'h3;
    localparam logic [15:0] MEAS_ONE      = 16'h0001;
    typedef enum logic [1:0] {PH_HIGH, PH_EXTEND, PH_LOW} phase_e;
    // odd ratio when high and low counts differ in parity
    function automatic logic ratioOdd(input logic [3:0] n, input logic [3:0] m);
        return n[0] ^ m[0];
    endfunction
    function automatic logic [5:0] stageRatio(input logic [3:0] n, input logic [3:0] m);
        return {2'h0, n} + {2'h0, m} + RATIO_OFFSET;
    endfunction
    // widened compare so a high count of 15 cannot wrap to a low count of 0
    function automatic logic stageLegal(input logic [3:0] n, input logic [3:0] m);
        if (ratioOdd(n, m))
            return {1'b0, m} == ({1'b0, n} + 5'h01);
        return m == n;
    endfunction
endpackage

//--- rtl/div_stage.sv
// one programmable divider stage with optional duty-cycle correction
module div_stage (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       inLvl,
    input  wire logic       bypass,
    input  wire logic       dutyFix,
    input  wire logic [3:0] nHigh,
    input  wire logic [3:0] mLow,
    output logic            outLvl
);
    divider_pkg::phase_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic       outLvl_q, outLvl_d;
    logic       inPrev_q;
    logic       inRise;
    logic       inFall;
    logic       odd;

    assign inRise = inLvl & ~inPrev_q;
    assign inFall = ~inLvl & inPrev_q;
    assign odd    = divider_pkg::ratioOdd(nHigh, mLow);
    assign outLvl = outLvl_q;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        outLvl_d = outLvl_q;
        if (bypass) begin
            outLvl_d = inLvl;
            state_d  = divider_pkg::PH_LOW;
            cnt_d    = '0;
        end else begin
            unique case (state_q)
                divider_pkg::PH_HIGH: begin
                    if (inRise) begin
                        if (cnt_q == nHigh) begin
                            cnt_d = '0;
                            // odd ratio: hold high into the next input high phase
                            if (dutyFix && odd) begin
                                state_d = divider_pkg::PH_EXTEND;
                            end else begin
                                state_d  = divider_pkg::PH_LOW;
                                outLvl_d = 1'b0;
                            end
                        end else begin
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                divider_pkg::PH_EXTEND: begin
                    if (inFall) begin
                        state_d  = divider_pkg::PH_LOW;
                        outLvl_d = 1'b0;
                    end
                end
                divider_pkg::PH_LOW: begin
                    if (inRise) begin
                        if (cnt_q == mLow) begin
                            state_d  = divider_pkg::PH_HIGH;
                            outLvl_d = 1'b1;
                            cnt_d    = '0;
                        end else begin
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q  <= divider_pkg::PH_LOW;
            cnt_q    <= '0;
            outLvl_q <= 1'b0;
            inPrev_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            outLvl_q <= outLvl_d;
            inPrev_q <= inLvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_HIGH_SPAN: assert property (
        (!bypass && state_q == divider_pkg::PH_HIGH && state_d == divider_pkg::PH_LOW)
        |-> (inRise && cnt_q == nHigh))
        else $error("high phase ended on a wrong count");
    AST_LOW_SPAN: assert property (
        (!bypass && $past(!bypass) && $rose(outLvl_q))
        |-> ($past(cnt_q) == $past(mLow) && $past(inRise)))
        else $error("low phase ended on a wrong count");
    AST_EXTEND_COND: assert property (
        ($changed(state_q) && state_q == divider_pkg::PH_EXTEND)
        |-> $past(dutyFix && odd))
        else $error("extension entered without correction on an odd ratio");
    AST_EXTEND_FALL: assert property (
        (state_q == divider_pkg::PH_EXTEND && inFall && !bypass) |=> !outLvl_q)
        else $error("extended high did not end at the input fall");
    AST_BYPASS_FOLLOW: assert property (
        $past(bypass) |-> outLvl_q == $past(inLvl))
        else $error("bypassed stage does not follow its input");
    COV_EXTEND: cover property (state_q == divider_pkg::PH_EXTEND ##1 !outLvl_q);
endmodule // div_stage

//--- rtl/divider_channel.sv
// two cascaded dividers behind an optional prescaler, with apb registers
// Notes on behaviour
// - uncorrected prescaler alone: 50, 33.3, 40 percent
// - uncorrected: high for count plus one
// - uncorrected, direct, bypassed: input duty passes
// - corrected with 50 percent input: 50 percent
// - corrected prescaler alone follows input duty formula
// - an even ratio with equal high and low counts gives 50 percent
// - stage counts plus one; ratio is product
// - correction on unless disable bit set
//
// The APB slave port and the placing of the registers were chosen for this implementation.
module divider_channel (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        prescaleIn,
    input  wire logic        extClkIn,
    output logic             chanOut
);
    logic        correctionDisable_q, correctionDisable_d;
    logic        useExt_q, useExt_d;
    logic        byp1_q, byp1_d;
    logic        byp2_q, byp2_d;
    logic [2:0]  prescale_q, prescale_d;
    logic [7:0]  stage1_q, stage1_d;
    logic [7:0]  stage2_q, stage2_d;
    logic [31:0] prdata_q, prdata_d;
    logic        preMeta_q, prePin_q;
    logic        extMeta_q, extPin_q;
    logic        wrEn;
    logic        hit;
    logic [31:0] readWord;
    logic [2:0]  preClamp;
    logic [3:0]  preN, preM;
    logic        preOut, srcLvl, s1Out, s2Out;
    logic        dutyFix;
    logic [3:0]  n1, m1, n2, m2;
    logic [10:0] ratio1, ratio2, totalRatio;
    logic        badBypass, badOrder, fixOk;
    logic [15:0] highCnt_q, highCnt_d;
    logic [15:0] perCnt_q, perCnt_d;
    logic [15:0] measHigh_q, measHigh_d;
    logic [15:0] measPer_q, measPer_d;
    logic        chanPrev_q;
    logic [1:0]  cfgAge_q, cfgAge_d;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first flops feed only the second
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            preMeta_q <= 1'b0;
            prePin_q  <= 1'b0;
            extMeta_q <= 1'b0;
            extPin_q  <= 1'b0;
        end else begin
            preMeta_q <= prescaleIn;
            prePin_q  <= preMeta_q;
            extMeta_q <= extClkIn;
            extPin_q  <= extMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: no wait states, read data captured in the setup cycle
    assign pready  = 1'b1;
    assign wrEn    = psel && penable && pwrite;
    assign prdata  = prdata_q;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        hit = 1'b1;
        readWord = '0;
        unique case (paddr)
            divider_pkg::OFF_CTRL: begin
                readWord[divider_pkg::CTRL_CORR_DIS] = correctionDisable_q;
                readWord[divider_pkg::CTRL_USE_EXT]  = useExt_q;
                readWord[divider_pkg::CTRL_BYP1]     = byp1_q;
                readWord[divider_pkg::CTRL_BYP2]     = byp2_q;
            end
            divider_pkg::OFF_PRESCALE: readWord[2:0] = prescale_q;
            divider_pkg::OFF_STAGE1:   readWord[7:0] = stage1_q;
            divider_pkg::OFF_STAGE2:   readWord[7:0] = stage2_q;
            divider_pkg::OFF_STATUS: begin
                readWord[divider_pkg::ST_OUT]       = chanOut;
                readWord[divider_pkg::ST_FIX_OK]    = fixOk;
                readWord[divider_pkg::ST_BAD_BYP]   = badBypass;
                readWord[divider_pkg::ST_BAD_ORDER] = badOrder;
                readWord[divider_pkg::ST_RATIO_LSB +: divider_pkg::RATIO_W] = totalRatio;
            end
            divider_pkg::OFF_MEASURE: begin
                readWord[0 +: divider_pkg::MEAS_W] = measHigh_q;
                readWord[divider_pkg::MEAS_PER_LSB +: divider_pkg::MEAS_W] = measPer_q;
            end
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        correctionDisable_d = correctionDisable_q;
        useExt_d   = useExt_q;
        byp1_d     = byp1_q;
        byp2_d     = byp2_q;
        prescale_d = prescale_q;
        stage1_d   = stage1_q;
        stage2_d   = stage2_q;
        prdata_d   = prdata_q;
        if (psel && !penable && !pwrite) begin
            prdata_d = readWord;
        end
        if (wrEn) begin
            unique case (paddr)
                divider_pkg::OFF_CTRL: begin
                    correctionDisable_d = pwdata[divider_pkg::CTRL_CORR_DIS];
                    useExt_d = pwdata[divider_pkg::CTRL_USE_EXT];
                    byp1_d   = pwdata[divider_pkg::CTRL_BYP1];
                    byp2_d   = pwdata[divider_pkg::CTRL_BYP2];
                end
                divider_pkg::OFF_PRESCALE: prescale_d = pwdata[2:0];
                divider_pkg::OFF_STAGE1:   stage1_d   = pwdata[7:0];
                divider_pkg::OFF_STAGE2:   stage2_d   = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            correctionDisable_q <= 1'b0;
            useExt_q   <= 1'b0;
            byp1_q     <= 1'b0;
            byp2_q     <= 1'b0;
            prescale_q <= divider_pkg::PRE_RESET;
            stage1_q   <= divider_pkg::STAGE_RESET;
            stage2_q   <= divider_pkg::STAGE_RESET;
            prdata_q   <= '0;
        end else begin
            correctionDisable_q <= correctionDisable_d;
            useExt_q   <= useExt_d;
            byp1_q     <= byp1_d;
            byp2_q     <= byp2_d;
            prescale_q <= prescale_d;
            stage1_q   <= stage1_d;
            stage2_q   <= stage2_d;
            prdata_q   <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler: out-of-range ratios are clamped rather than left undefined
    always_comb begin
        preClamp = prescale_q;
        if (prescale_q < divider_pkg::PRE_MIN)
            preClamp = divider_pkg::PRE_MIN;
        else if (prescale_q > divider_pkg::PRE_MAX)
            preClamp = divider_pkg::PRE_MAX;
    end
    // even: equal halves; three gives one high of three, five two of five
    assign preN = {2'h0, preClamp[2:1]} - 4'h1;
    assign preM = {1'b0, preClamp} - {2'h0, preClamp[2:1]} - 4'h1;

    assign dutyFix = !correctionDisable_q;
    assign n1 = stage1_q[3:0];
    assign m1 = stage1_q[7:4];
    assign n2 = stage2_q[3:0];
    assign m2 = stage2_q[7:4];

    div_stage preStage (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .inLvl   (prePin_q),
        .bypass  (1'b0),
        .dutyFix (dutyFix),
        .nHigh   (preN),
        .mLow    (preM),
        .outLvl  (preOut)
    );

    assign srcLvl = useExt_q ? extPin_q : preOut;

    div_stage firstStage (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .inLvl   (srcLvl),
        .bypass  (byp1_q),
        .dutyFix (dutyFix),
        .nHigh   (n1),
        .mLow    (m1),
        .outLvl  (s1Out)
    );

    div_stage secondStage (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .inLvl   (s1Out),
        .bypass  (byp2_q),
        .dutyFix (dutyFix),
        .nHigh   (n2),
        .mLow    (m2),
        .outLvl  (s2Out)
    );

    assign chanOut = s2Out;

    ////////////////////////////////////////////////////////////////////////////
    // total_ratio and correction-legality status
    assign ratio1 = byp1_q ? divider_pkg::RATIO_ONE
                           : {5'h00, divider_pkg::stageRatio(n1, m1)};
    assign ratio2 = byp2_q ? divider_pkg::RATIO_ONE
                           : {5'h00, divider_pkg::stageRatio(n2, m2)};
    assign totalRatio = ratio1 * ratio2;
    assign badBypass  = byp1_q && !byp2_q;
    assign badOrder   = !byp1_q && !byp2_q && !divider_pkg::ratioOdd(n1, m1)
                        && divider_pkg::ratioOdd(n2, m2);
    // settings outside this leave the corrected duty unspecified
    assign fixOk = (byp1_q || divider_pkg::stageLegal(n1, m1))
                   && (byp2_q || divider_pkg::stageLegal(n2, m2))
                   && !badBypass && !badOrder;

    ////////////////////////////////////////////////////////////////////////////
    // duty measurement of the last full output period, in clk_sys cycles;
    // counts saturate, so very slow outputs read as the largest value
    always_comb begin
        highCnt_d  = highCnt_q;
        perCnt_d   = perCnt_q;
        measHigh_d = measHigh_q;
        measPer_d  = measPer_q;
        cfgAge_d   = cfgAge_q;
        if (chanOut && !chanPrev_q) begin
            measHigh_d = highCnt_q;
            measPer_d  = perCnt_q;
            highCnt_d  = divider_pkg::MEAS_ONE;
            perCnt_d   = divider_pkg::MEAS_ONE;
        end else begin
            if (chanOut && highCnt_q != '1)
                highCnt_d = highCnt_q + divider_pkg::MEAS_ONE;
            if (perCnt_q != '1)
                perCnt_d = perCnt_q + divider_pkg::MEAS_ONE;
        end
        if (wrEn)
            cfgAge_d = '0;
        else if (cfgAge_q != divider_pkg::CFG_SETTLED)
            cfgAge_d = cfgAge_q + 2'h1;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            highCnt_q  <= '0;
            perCnt_q   <= '0;
            measHigh_q <= '0;
            measPer_q  <= '0;
            chanPrev_q <= 1'b0;
            cfgAge_q   <= '0;
        end else begin
            highCnt_q  <= highCnt_d;
            perCnt_q   <= perCnt_d;
            measHigh_q <= measHigh_d;
            measPer_q  <= measPer_d;
            chanPrev_q <= chanOut;
            cfgAge_q   <= cfgAge_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_PASS_THROUGH: assert property (
        (cfgAge_q == divider_pkg::CFG_SETTLED && correctionDisable_q && useExt_q
         && byp1_q && byp2_q) |-> chanOut == $past(extPin_q, 2))
        else $error("direct bypassed path does not pass the input");
    AST_DEFAULT_FIX: assert property (
        $rose(correctionDisable_q)
        |-> $past(wrEn && paddr == divider_pkg::OFF_CTRL
                  && pwdata[divider_pkg::CTRL_CORR_DIS]))
        else $error("correction turned off without a control write");
    AST_RATIO_PRODUCT: assert property (
        (byp1_q && byp2_q) |-> totalRatio == divider_pkg::RATIO_ONE)
        else $error("both stages bypassed but ratio is not one");
    AST_PRESCALE_SPLIT: assert property (
        divider_pkg::stageLegal(preN, preM)
        && divider_pkg::stageRatio(preN, preM) == {3'h0, preClamp})
        else $error("prescale ratio not split into legal high and low counts");
    AST_APB_READ: assert property (
        (psel && !penable && !pwrite) |=> (prdata == $past(readWord)))
        else $error("read data not captured in setup");
    COV_PASS: cover property (correctionDisable_q && useExt_q && byp1_q && byp2_q
                              ##1 $rose(chanOut));
    COV_CASCADE: cover property (!byp1_q && !byp2_q && fixOk && $rose(chanOut));
    COV_WRITE: cover property (wrEn ##1 !wrEn ##1 $rose(chanOut));
endmodule // divider_channel

//--- verif/clk_src.sv
// clock source model driving one clock pin of the channel
module clk_src (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [3:0] hiLen,
    input  wire logic [3:0] loLen,
    output logic            pinOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // runs free like an oscillator; lengths under 2 would outrun the pin synchroniser
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt    <= 4'h1;
            pinOut <= 1'b0;
        end else if (cnt >= (pinOut ? hiLen : loLen)) begin
            cnt    <= 4'h1;
            pinOut <= ~pinOut;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // clk_src

//--- verif/tb.sv
// self-checking bench for the cascaded divider channel
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic        prescaleIn, extClkIn, chanOut;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  hiLen, loLen;
    int          bad_count, checked;

    divider_channel i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prescaleIn(prescaleIn), .extClkIn(extClkIn), .chanOut(chanOut));
    clk_src i_pre (.clk_sys(clk_sys), .rstn(rstn), .hiLen(hiLen), .loLen(loLen),
        .pinOut(prescaleIn));
    clk_src i_ext (.clk_sys(clk_sys), .rstn(rstn), .hiLen(hiLen), .loLen(loLen),
        .pinOut(extClkIn));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // one stage: high for n+1 input periods, extended by the input high when corrected odd
    function automatic void stg(inout int t, inout int h, inout int r, input int n, input int m,
                                input int dis);
        h = (n + 1) * t + ((dis == 0 && (n + m) % 2 == 1) ? h : 0);
        t = t * (n + m + 2);
        r = r * (n + m + 2);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // sampled on the falling edge so output updates have settled
    task automatic measure(output int hi, output int per);
        int k;
        k = 0;
        hi = 0;
        per = 0;
        while (chanOut !== 1'b0 && k < 6000) begin
            @(negedge clk_sys);
            k++;
        end
        while (chanOut !== 1'b1 && k < 6000) begin
            @(negedge clk_sys);
            k++;
        end
        while (chanOut === 1'b1 && per < 6000) begin
            @(negedge clk_sys);
            hi++;
            per++;
        end
        while (chanOut === 1'b0 && per < 6000) begin
            @(negedge clk_sys);
            per++;
        end
    endtask

    task automatic run_case(input string nm, input int dis, input int ext, input int b1,
                            input int b2, input int p, input int n1, input int m1,
                            input int n2, input int m2, input int hi, input int lo);
        int t, h, r, mh, mp;
        hiLen <= hi[3:0];
        loLen <= lo[3:0];
        apb(1'b1, divider_pkg::OFF_PRESCALE, p);
        apb(1'b1, divider_pkg::OFF_STAGE1, {24'h0, m1[3:0], n1[3:0]});
        apb(1'b1, divider_pkg::OFF_STAGE2, {24'h0, m2[3:0], n2[3:0]});
        apb(1'b1, divider_pkg::OFF_CTRL, {28'h0, b2[0], b1[0], ext[0], dis[0]});
        t = (ext != 0) ? hi + lo : (hi + lo) * p;
        h = (ext != 0) ? hi : (p / 2) * (hi + lo) + ((dis == 0 && p % 2 == 1) ? hi : 0);
        r = 1;
        if (b1 == 0)
            stg(t, h, r, n1, m1, dis);
        if (b2 == 0)
            stg(t, h, r, n2, m2, dis);
        // periods around a write are undefined, so only the third one counts
        repeat (3) measure(mh, mp);
        check({nm, " high"}, mh, h);
        check({nm, " period"}, mp, t);
        apb(1'b0, divider_pkg::OFF_MEASURE, 32'h0);
        check({nm, " measure"}, rd, {t[15:0], h[15:0]});
        apb(1'b0, divider_pkg::OFF_STATUS, 32'h0);
        check({nm, " ratio"}, rd[divider_pkg::ST_RATIO_LSB +: divider_pkg::RATIO_W], r);
        check({nm, " fix ok"}, rd[divider_pkg::ST_FIX_OK], 1'b1);
        $display("test %s done", nm);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        // slow prescaler into two active stages dominates the run time
        repeat (95000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end

    initial begin
        int p, b, n1, n2, o1, o2;
        {rstn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hiLen = 4'h2;
        loLen = 4'h2;
        seed = 32'ha985;
        bad_count = 0;
        checked = 0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(1'b0, divider_pkg::OFF_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, divider_pkg::OFF_PRESCALE, 32'h0);
        check("prescale reset", rd, 32'h2);
        apb(1'b0, divider_pkg::OFF_STATUS, 32'h0);
        check("fix ok reset", rd[divider_pkg::ST_FIX_OK], 1'b1);
        check("ratio reset", rd[divider_pkg::ST_RATIO_LSB +: divider_pkg::RATIO_W], 4);
        apb(1'b0, 8'h3c, 32'h0);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        $display("test defaults done");
        for (p = 2; p <= 6; p++)
            run_case("prescale_only", 1, 0, 1, 1, p, 0, 0, 0, 0, 2, 2);
        run_case("fixed_by3", 0, 0, 1, 1, 3, 0, 0, 0, 0, 2, 3);
        run_case("fixed_by5", 0, 0, 1, 1, 5, 0, 0, 0, 0, 3, 2);
        run_case("direct_raw", 1, 1, 1, 1, 2, 0, 0, 0, 0, 3, 2);
        run_case("direct_fixed", 0, 1, 1, 1, 2, 0, 0, 0, 0, 2, 3);
        // illegal settings: flags only, the duty is left unchecked
        apb(1'b1, divider_pkg::OFF_CTRL, 32'h4);
        apb(1'b0, divider_pkg::OFF_STATUS, 32'h0);
        check("first bypassed flag", rd[divider_pkg::ST_BAD_BYP], 1'b1);
        check("first bypassed fix ok", rd[divider_pkg::ST_FIX_OK], 1'b0);
        apb(1'b1, divider_pkg::OFF_STAGE2, 32'h10);
        apb(1'b1, divider_pkg::OFF_CTRL, 32'h0);
        apb(1'b0, divider_pkg::OFF_STATUS, 32'h0);
        check("even first flag", rd[divider_pkg::ST_BAD_ORDER], 1'b1);
        check("even first fix ok", rd[divider_pkg::ST_FIX_OK], 1'b0);
        $display("test flags done");
        for (b = 0; b < 6; b++) begin
            n1 = rnd() % 3;
            n2 = rnd() % 3;
            o1 = rnd() % 2;
            o2 = rnd() % 2;
            if (o1 == 0 && o2 == 1) begin
                o1 = 1;
                o2 = 0;
            end
            run_case("random", rnd() % 2, rnd() % 2, 0, rnd() % 2, 2 + rnd() % 5, n1, n1 + o1,
                     n2, n2 + o2, 2 + rnd() % 2, 2 + rnd() % 2);
        end
        close_out();
    end
endmodule // tb
